// >>> rtl/ext_feat_pkg.sv
package ext_feat_pkg;

  // Model-specific register address of the extended feature control register
  localparam logic [31:0] EXT_FEAT_CTRL_ADDR = 32'hC000_0080;

  // Field positions
  localparam int FAST_CALL_ENABLE_BIT      = 0;
  localparam int WIDE_MODE_ENABLE_BIT      = 8;
  localparam int WIDE_MODE_ACTIVE_BIT      = 10;
  localparam int NO_EXEC_ENABLE_BIT        = 11;
  localparam int VIRT_EXT_ENABLE_BIT       = 12;
  localparam int WIDE_SEG_LIMIT_ENABLE_BIT = 13;
  localparam int FAST_STATE_SAVE_BIT       = 14;

  // Reset values
  localparam logic [63:0] EXT_FEAT_RESET    = 64'h0000_0000_0000_0000;
  localparam logic        WIDE_ACTIVE_RESET = 1'b0;

  // Software-writable bits; everything else is read-only or undefined
  localparam logic [63:0] EXT_FEAT_WRITE_MASK =
    (64'h1 << FAST_CALL_ENABLE_BIT) |
    (64'h1 << WIDE_MODE_ENABLE_BIT) |
    (64'h1 << NO_EXEC_ENABLE_BIT) |
    (64'h1 << VIRT_EXT_ENABLE_BIT) |
    (64'h1 << WIDE_SEG_LIMIT_ENABLE_BIT) |
    (64'h1 << FAST_STATE_SAVE_BIT);

  // Highest privilege level, the only one allowed to reach model-specific registers
  localparam logic [1:0] PRIV_LEVEL_KERNEL = 2'h0;

  typedef enum logic [1:0] {
    MODE_LEGACY,
    MODE_COMPAT,
    MODE_WIDE64
  } cpu_mode_t;

  typedef enum logic [2:0] {
    INSTR_OTHER,
    INSTR_FAST_CALL,
    INSTR_FAST_RETURN,
    INSTR_VIRT,
    INSTR_STATE_SAVE,
    INSTR_STATE_RESTORE
  } instr_class_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [63:0] wdata;
  } msr_req_t;

  typedef struct packed {
    logic        ack;
    logic        privFault;
    logic        miss;
    logic [63:0] rdata;
  } msr_rsp_t;

  typedef struct packed {
    logic         valid;
    instr_class_t kind;
  } instr_req_t;

  typedef struct packed {
    logic done;
    logic undefinedOpcodeFault;
    logic skipVectorRegs;
    logic saveLegacyFpState;
    logic saveVectorCtrlStatus;
  } instr_rsp_t;

endpackage : ext_feat_pkg

// >>> rtl/msr_access_check.sv
`timescale 1ns/1ps
module msr_access_check
(
  // Access from the model-specific-register read and write instructions
  input  wire ext_feat_pkg::msr_req_t msrReq,
  input  wire logic [1:0]             privLevel,
  // Decoded access
  output logic                        privFault,
  output logic                        readHit,
  output logic                        writeHit,
  output logic                        addrMiss
);

  function automatic logic isExtFeatAddr(input logic [31:0] addr);
    isExtFeatAddr = (addr == ext_feat_pkg::EXT_FEAT_CTRL_ADDR);
  endfunction : isExtFeatAddr

  wire logic privOk;
  wire logic addrHit;

  assign privOk    = (privLevel == ext_feat_pkg::PRIV_LEVEL_KERNEL);
  assign addrHit   = isExtFeatAddr(msrReq.addr);
  assign privFault = msrReq.valid & ~privOk;
  assign readHit   = msrReq.valid & privOk & addrHit & ~msrReq.write;
  assign writeHit  = msrReq.valid & privOk & addrHit & msrReq.write;
  assign addrMiss  = msrReq.valid & privOk & ~isExtFeatAddr(msrReq.addr);

endmodule : msr_access_check

// >>> rtl/extended_feature_control_reg.sv
`timescale 1ns/1ps
module extended_feature_control_reg
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  // Model-specific-register instruction port
  input  wire ext_feat_pkg::msr_req_t     msrReq,
  output ext_feat_pkg::msr_rsp_t          msrRsp,
  // Core state on the same clock
  input  wire logic [1:0]                 privLevel,
  input  wire logic                       pagingEnable,
  input  wire logic                       codeSegWide,
  input  wire logic                       virtLockout,
  // Instruction gating
  input  wire ext_feat_pkg::instr_req_t   instrReq,
  output ext_feat_pkg::instr_rsp_t        instrRsp,
  // Feature controls to the core
  output ext_feat_pkg::cpu_mode_t         cpuMode,
  output logic                            wideModeActive,
  output logic                            fastCallAllowed,
  output logic                            noExecProtect,
  output logic                            virtExtAvailable,
  output logic                            wideSegLimitCheck
);

  wire logic [63:0]          ctrl_r;
  logic [63:0]               ctrl_nxt;
  logic                      wideActive_r;
  logic                      wideActive_nxt;
  logic                      pagingPrev_r;
  ext_feat_pkg::msr_rsp_t    rsp_r;
  ext_feat_pkg::msr_rsp_t    rsp_nxt;
  ext_feat_pkg::instr_rsp_t  irsp_r;
  ext_feat_pkg::instr_rsp_t  irsp_nxt;
  ext_feat_pkg::cpu_mode_t   mode_r;
  ext_feat_pkg::cpu_mode_t   mode_nxt;
  logic                      fastCall_r;
  logic                      noExec_r;
  logic                      virtAvail_r;
  logic                      segLimit_r;

  wire logic                 privFault;
  wire logic                 readHit;
  wire logic                 writeHit;
  wire logic                 addrMiss;

  // Shared decodes
  function automatic logic isWide64(input ext_feat_pkg::cpu_mode_t mode);
    isWide64 = (mode == ext_feat_pkg::MODE_WIDE64);
  endfunction : isWide64

  function automatic logic isKernel(input logic [1:0] level);
    isKernel = (level == ext_feat_pkg::PRIV_LEVEL_KERNEL);
  endfunction : isKernel

  function automatic logic isKind(input ext_feat_pkg::instr_class_t kind,
                                  input ext_feat_pkg::instr_class_t want);
    isKind = (kind == want);
  endfunction : isKind

  msr_access_check u_access
  (
    .msrReq    (msrReq),
    .privLevel (privLevel),
    .privFault (privFault),
    .readHit   (readHit),
    .writeHit  (writeHit),
    .addrMiss  (addrMiss)
  );

  // Register image and writes
  wire logic [63:0] readValue;
  wire logic [63:0] writeValue;

  assign readValue =
    (ctrl_r & ext_feat_pkg::EXT_FEAT_WRITE_MASK) |
    ({63'h0, wideActive_r} << ext_feat_pkg::WIDE_MODE_ACTIVE_BIT);

  assign writeValue = msrReq.wdata & ext_feat_pkg::EXT_FEAT_WRITE_MASK;

  assign ctrl_nxt = writeHit ? writeValue : ctrl_r;

  // One storage flop per writable position; the other positions stay zero
  for (genvar bitIdx = 0; bitIdx < 64; bitIdx++)
  begin : g_ctrl_bit
    if (ext_feat_pkg::EXT_FEAT_WRITE_MASK[bitIdx])
    begin : g_store
      logic store_r;
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          store_r <= ext_feat_pkg::EXT_FEAT_RESET[bitIdx];
        end
        else
        begin
          store_r <= ctrl_nxt[bitIdx];
        end
      end
      assign ctrl_r[bitIdx] = store_r;
    end
    else
    begin : g_none
      assign ctrl_r[bitIdx] = 1'b0;
    end
  end

  // Field views of the stored enables
  wire logic wideEnable;
  wire logic fastCallEn;
  wire logic noExecEn;
  wire logic virtEn;
  wire logic segLimitEn;
  wire logic fastSaveEn;

  assign wideEnable = ctrl_r[ext_feat_pkg::WIDE_MODE_ENABLE_BIT];
  assign fastCallEn = ctrl_r[ext_feat_pkg::FAST_CALL_ENABLE_BIT];
  assign noExecEn   = ctrl_r[ext_feat_pkg::NO_EXEC_ENABLE_BIT];
  assign virtEn     = ctrl_r[ext_feat_pkg::VIRT_EXT_ENABLE_BIT];
  assign segLimitEn = ctrl_r[ext_feat_pkg::WIDE_SEG_LIMIT_ENABLE_BIT];
  assign fastSaveEn = ctrl_r[ext_feat_pkg::FAST_STATE_SAVE_BIT];

  // Activation happens on the paging turn-on, never on the enable write itself
  wire logic pagingRise;

  assign pagingRise     = pagingEnable & ~pagingPrev_r;
  assign wideActive_nxt = ~pagingEnable ? 1'b0 :
                          (pagingRise & wideEnable) ? 1'b1 : wideActive_r;

  // Operating submode
  assign mode_nxt = ~wideActive_r ? ext_feat_pkg::MODE_LEGACY :
                    codeSegWide   ? ext_feat_pkg::MODE_WIDE64 :
                                    ext_feat_pkg::MODE_COMPAT;

  // Effective feature enables
  wire logic virtUsable;
  wire logic in64;
  wire logic atKernel;

  assign virtUsable = virtEn & ~virtLockout;
  assign in64       = isWide64(mode_r);
  assign atKernel   = isKernel(privLevel);

  // Instruction gating
  wire logic isFastCall;
  wire logic isVirt;
  wire logic isSave;
  wire logic udFault;

  assign isFastCall = isKind(instrReq.kind, ext_feat_pkg::INSTR_FAST_CALL) |
                      isKind(instrReq.kind, ext_feat_pkg::INSTR_FAST_RETURN);
  assign isVirt     = isKind(instrReq.kind, ext_feat_pkg::INSTR_VIRT);
  assign isSave     = isKind(instrReq.kind, ext_feat_pkg::INSTR_STATE_SAVE) |
                      isKind(instrReq.kind, ext_feat_pkg::INSTR_STATE_RESTORE);
  assign udFault    = (isFastCall & ~fastCallEn) |
                      (isVirt & ~virtUsable);

  always_comb
  begin
    irsp_nxt                      = '0;
    irsp_nxt.done                 = instrReq.valid;
    irsp_nxt.undefinedOpcodeFault = instrReq.valid & udFault;
    irsp_nxt.skipVectorRegs       = instrReq.valid & isSave & fastSaveEn &
                                    in64 & atKernel;
    irsp_nxt.saveLegacyFpState    = instrReq.valid & isSave;
    irsp_nxt.saveVectorCtrlStatus = instrReq.valid & isSave;
  end

  // Register access answer, one cycle after the request
  always_comb
  begin
    rsp_nxt           = '0;
    rsp_nxt.ack       = msrReq.valid;
    rsp_nxt.privFault = privFault;
    rsp_nxt.miss      = addrMiss;
    rsp_nxt.rdata     = readHit ? readValue : 64'h0000_0000_0000_0000;
  end

  // Wide mode activation and the paging edge it waits for
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wideActive_r <= ext_feat_pkg::WIDE_ACTIVE_RESET;
    end
    else
    begin
      wideActive_r <= wideActive_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pagingPrev_r <= 1'b0;
    end
    else
    begin
      pagingPrev_r <= pagingEnable;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_r <= '0;
    end
    else
    begin
      rsp_r <= rsp_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irsp_r <= '0;
    end
    else
    begin
      irsp_r <= irsp_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_r <= ext_feat_pkg::MODE_LEGACY;
    end
    else
    begin
      mode_r <= mode_nxt;
    end
  end

  // Feature controls, registered from the enables; only the segment limit check is held off outside MODE_WIDE64
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fastCall_r  <= 1'b0;
      noExec_r    <= 1'b0;
      virtAvail_r <= 1'b0;
    end
    else
    begin
      fastCall_r  <= fastCallEn;
      noExec_r    <= noExecEn;
      virtAvail_r <= virtUsable;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      segLimit_r <= 1'b0;
    end
    else
    begin
      segLimit_r <= segLimitEn & isWide64(mode_nxt);
    end
  end

  assign msrRsp            = rsp_r;
  assign instrRsp          = irsp_r;
  assign cpuMode           = mode_r;
  assign wideModeActive    = wideActive_r;
  assign fastCallAllowed   = fastCall_r;
  assign noExecProtect     = noExec_r;
  assign virtExtAvailable  = virtAvail_r;
  assign wideSegLimitCheck = segLimit_r;

endmodule : extended_feature_control_reg

// >>> test/ext_feat_sva.sv
`timescale 1ns/1ps
module ext_feat_sva
(
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     reset_n,
  // Observed ports
  input wire ext_feat_pkg::msr_req_t   msrReq,
  input wire ext_feat_pkg::msr_rsp_t   msrRsp,
  input wire logic [1:0]               privLevel,
  input wire logic                     pagingEnable,
  input wire logic                     codeSegWide,
  input wire ext_feat_pkg::instr_req_t instrReq,
  input wire ext_feat_pkg::instr_rsp_t instrRsp,
  input wire ext_feat_pkg::cpu_mode_t  cpuMode,
  input wire logic                     wideModeActive,
  input wire logic                     fastCallAllowed,
  input wire logic                     virtExtAvailable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire logic kern = msrReq.valid && privLevel == 2'h0;
  wire logic hit  = kern && msrReq.addr == ext_feat_pkg::EXT_FEAT_CTRL_ADDR;
  wire logic sav  = instrReq.valid && instrReq.kind inside
    {ext_feat_pkg::INSTR_STATE_SAVE, ext_feat_pkg::INSTR_STATE_RESTORE};
  property p_priv;
    msrReq.valid && privLevel != 2'h0 |=> msrRsp.privFault && msrRsp.rdata == 64'h0;
  endproperty
  a_priv: assert property (p_priv) else $error("unprivileged access not refused");
  property p_miss;
    kern && !hit |=> msrRsp.miss && msrRsp.rdata == 64'h0;
  endproperty
  a_miss: assert property (p_miss) else $error("other address not reported");
  property p_undef;
    msrRsp.ack |-> (msrRsp.rdata & ~(ext_feat_pkg::EXT_FEAT_WRITE_MASK | 64'h400)) == 64'h0;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined bits read nonzero");
  property p_active_rd;
    hit && !msrReq.write |=> msrRsp.rdata[10] == $past(wideModeActive);
  endproperty
  a_active_rd: assert property (p_active_rd) else $error("active bit image wrong");
  property p_activate;
    $rose(wideModeActive) |-> $past(pagingEnable) && !$past(pagingEnable, 2);
  endproperty
  a_activate: assert property (p_activate) else $error("activation without paging rise");
  property p_legacy;
    !wideModeActive |=> cpuMode == ext_feat_pkg::MODE_LEGACY;
  endproperty
  a_legacy: assert property (p_legacy) else $error("mode not legacy while inactive");
  property p_submode;
    wideModeActive [*2] ##0 $stable(codeSegWide) |-> cpuMode ==
      (codeSegWide ? ext_feat_pkg::MODE_WIDE64 : ext_feat_pkg::MODE_COMPAT);
  endproperty
  a_submode: assert property (p_submode) else $error("submode not from wide flag");
  property p_fastcall;
    instrReq.valid && instrReq.kind == ext_feat_pkg::INSTR_FAST_CALL |=>
      instrRsp.done && instrRsp.undefinedOpcodeFault == !fastCallAllowed;
  endproperty
  a_fastcall: assert property (p_fastcall) else $error("fast call gating wrong");
  property p_virt;
    instrReq.valid && instrReq.kind == ext_feat_pkg::INSTR_VIRT |=>
      instrRsp.undefinedOpcodeFault == !virtExtAvailable;
  endproperty
  a_virt: assert property (p_virt) else $error("virtualization gating wrong");
  property p_no_skip;
    sav && (privLevel != 2'h0 || cpuMode != ext_feat_pkg::MODE_WIDE64) |=>
      !instrRsp.skipVectorRegs && instrRsp.saveLegacyFpState && instrRsp.saveVectorCtrlStatus;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("vector skip out of mode");
  c_act: cover property ($rose(wideModeActive));
  c_fault: cover property (msrRsp.privFault);
  c_skip: cover property (instrRsp.skipVectorRegs);
endmodule : ext_feat_sva

bind extended_feature_control_reg ext_feat_sva u_sva (.clk_sys, .reset_n, .msrReq, .msrRsp,
  .privLevel, .pagingEnable, .codeSegWide, .instrReq, .instrRsp, .cpuMode, .wideModeActive,
  .fastCallAllowed, .virtExtAvailable);

// >>> test/extended_feature_control_reg_tb.sv
`timescale 1ns/1ps
module extended_feature_control_reg_tb;
  logic                     clk_sys = 1'b0;
  logic                     reset_n = 1'b0;
  ext_feat_pkg::msr_req_t   msrReq = '0;
  ext_feat_pkg::msr_rsp_t   msrRsp, rsp;
  ext_feat_pkg::instr_req_t instrReq = '0;
  ext_feat_pkg::instr_rsp_t instrRsp;
  ext_feat_pkg::cpu_mode_t  cpuMode;
  logic [1:0]               privLevel = 2'h0;
  logic                     pagingEnable = 1'b0, codeSegWide = 1'b0, virtLockout = 1'b0;
  logic                     wideModeActive, fastCallAllowed, noExecProtect;
  logic                     virtExtAvailable, wideSegLimitCheck;
  logic [63:0]              w;
  int                       miscompares = 0, testsRun = 0;
  localparam logic [31:0]   A = ext_feat_pkg::EXT_FEAT_CTRL_ADDR;
  localparam logic [63:0]   M = ext_feat_pkg::EXT_FEAT_WRITE_MASK;

  extended_feature_control_reg u_dut (.clk_sys, .reset_n, .msrReq, .msrRsp, .privLevel,
    .pagingEnable, .codeSegWide, .virtLockout, .instrReq, .instrRsp, .cpuMode, .wideModeActive,
    .fastCallAllowed, .noExecProtect, .virtExtAvailable, .wideSegLimitCheck);

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [63:0] image(input logic [63:0] d, input logic act);
    return (d & M) | ({63'h0, act} << 10);
  endfunction : image

  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    testsRun++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk

  task msr(input logic wr, input logic [31:0] a, input logic [63:0] d);
    @(negedge clk_sys);
    msrReq = '{1'b1, wr, a, d};
    @(negedge clk_sys);
    msrReq.valid = 1'b0;
    rsp = msrRsp;
  endtask : msr

  task ins(input ext_feat_pkg::instr_class_t k);
    @(negedge clk_sys);
    instrReq = '{1'b1, k};
    @(negedge clk_sys);
    instrReq.valid = 1'b0;
  endtask : ins

  task endOfTest;
    $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : endOfTest

  initial
  begin
    #200000;
    miscompares++;
    endOfTest();
  end

  initial
  begin
    void'($urandom(83));
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    msr(1'b0, A, 64'h0);
    chk("reset image", rsp.rdata, 64'h0);
    chk("reset ack", rsp.ack, 1'b1);
    chk("reset mode", cpuMode, ext_feat_pkg::MODE_LEGACY);
    repeat (16)
    begin
      w = {$urandom, $urandom};
      virtLockout = w[1];
      msr(1'b1, A, w);
      msr(1'b0, A, 64'h0);
      chk("image", rsp.rdata, image(w, 1'b0));
      chk("fast call", fastCallAllowed, w[0]);
      chk("no exec", noExecProtect, w[11]);
      chk("virt", virtExtAvailable, w[12] & ~w[1]);
      ins(ext_feat_pkg::INSTR_FAST_CALL);
      chk("call fault", instrRsp.undefinedOpcodeFault, !w[0]);
      chk("call done", instrRsp.done, 1'b1);
      ins(ext_feat_pkg::INSTR_FAST_RETURN);
      chk("return fault", instrRsp.undefinedOpcodeFault, !w[0]);
      ins(ext_feat_pkg::INSTR_VIRT);
      chk("virt fault", instrRsp.undefinedOpcodeFault, !(w[12] && !w[1]));
    end
    privLevel = 2'($urandom_range(3, 1));
    msr(1'b1, A, ~w);
    chk("priv fault", rsp.privFault, 1'b1);
    privLevel = 2'h0;
    msr(1'b0, A, 64'h0);
    chk("kept", rsp.rdata, image(w, 1'b0));
    msr(1'b0, A + 32'h1, 64'h0);
    chk("miss", rsp.miss, 1'b1);
    msr(1'b1, A, 64'h0);
    pagingEnable = 1'b1;
    msr(1'b1, A, ~64'h0);
    repeat (3) @(negedge clk_sys);
    chk("no early active", wideModeActive, 1'b0);
    pagingEnable = 1'b0;
    codeSegWide = 1'b1;
    @(negedge clk_sys);
    pagingEnable = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("active", wideModeActive, 1'b1);
    msr(1'b1, A, M);
    msr(1'b0, A, 64'h0);
    chk("active kept", rsp.rdata, image(M, 1'b1));
    chk("wide mode", cpuMode, ext_feat_pkg::MODE_WIDE64);
    chk("limit check", wideSegLimitCheck, 1'b1);
    ins(ext_feat_pkg::INSTR_STATE_SAVE);
    chk("skip", instrRsp.skipVectorRegs, 1'b1);
    chk("fp kept", instrRsp.saveLegacyFpState, 1'b1);
    privLevel = 2'h3;
    ins(ext_feat_pkg::INSTR_STATE_RESTORE);
    chk("no skip priv", instrRsp.skipVectorRegs, 1'b0);
    privLevel = 2'h0;
    codeSegWide = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("compat", cpuMode, ext_feat_pkg::MODE_COMPAT);
    chk("no limit", wideSegLimitCheck, 1'b0);
    ins(ext_feat_pkg::INSTR_STATE_SAVE);
    chk("no skip compat", instrRsp.skipVectorRegs, 1'b0);
    reset_n = 1'b0;
    @(negedge clk_sys);
    reset_n = 1'b1;
    msr(1'b0, A, 64'h0);
    chk("reset again", rsp.rdata, 64'h0);
    chk("virt after reset", virtExtAvailable, 1'b0);
    chk("inactive after reset", wideModeActive, 1'b0);
    endOfTest();
  end
endmodule : extended_feature_control_reg_tb
